/* File: inc/sld_map.svh */
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// register addresses
`define SLD_ADDR_MODE      16'hFFB0
`define SLD_ADDR_CLOCK     16'hFFB2
`define SLD_ADDR_BOOST     16'hFFB3
`define SLD_RAM_BASE       16'hFA00
`define SLD_RAM_LAST       16'hFA0E
`define SLD_SEG_COUNT      15
`define SLD_REG_RESET      8'h00

// display mode register fields
`define SLD_MODE_MASK      8'hD1
`define SLD_BIT_ON         7
`define SLD_BIT_BOOST      6
`define SLD_BIT_OUT_EN     4
`define SLD_BIT_SLOTS      0

// clock and boost register fields
`define SLD_CLOCK_MASK     8'h0F
`define SLD_BOOST_MASK     8'h01
`define SLD_BIT_GAIN       0
`define SLD_RAM_MASK       4'hF

// clock division: source is the subsystem tick for sel 0, else fx/2^(4+sel); lcd clock = source/2^(6+sel)
`define SLD_SRC_SHIFT      3'h4
`define SLD_DIV_SHIFT      4'h6

// drive levels in thirds of the pixel-on voltage; level 0 is ground
`define SLD_LVL_0          2'h0
`define SLD_LVL_1          2'h1
`define SLD_LVL_2          2'h2
`define SLD_LVL_3          2'h3

`endif

/* File: inc/sld_pkg.sv */
package sld_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } sld_bus_s;

    typedef enum logic [3:0] {
        SLOT_0 = 4'b0001,
        SLOT_1 = 4'b0010,
        SLOT_2 = 4'b0100,
        SLOT_3 = 4'b1000
    } sld_slot_e;

endpackage : sld_pkg

/* File: design/sld_lcd_driver.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sld_map.svh"

module sld_lcd_driver (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // cpu memory access
    input  wire sld_pkg::sld_bus_s        bus_i,
    output logic [7:0]                    rdata_o,
    // subsystem clock, one-cycle enable per period
    input  wire logic                     fxt_tick_i,
    // panel drive, levels in thirds of the pixel-on voltage
    output logic [`SLD_SEG_COUNT-1:0][1:0] segment_o,
    output logic [3:0][1:0]               common_o,
    output logic [3:0]                    common_oe_o,
    // booster control
    output logic                          booster_enable_o,
    output logic                          gain_o
);

    logic [7:0]                     display_mode_reg, next_display_mode_reg;
    logic [7:0]                     lcd_clock_reg, next_lcd_clock_reg;
    logic [7:0]                     boost_level_reg, next_boost_level_reg;
    logic [3:0]                     ram [`SLD_SEG_COUNT];
    logic [3:0]                     next_ram [`SLD_SEG_COUNT];
    logic [7:0]                     next_rdata;
    logic [6:0]                     prescale, next_prescale;
    logic [8:0]                     lcd_div, next_lcd_div;
    sld_pkg::sld_slot_e             slot, next_slot;
    logic                           pol, next_pol;
    logic [`SLD_SEG_COUNT-1:0][1:0] next_segment;
    logic [3:0][1:0]                next_common;
    logic [3:0]                     next_common_oe;
    logic                           src_tick;
    logic                           lcd_tick;
    logic                           three_slot;
    logic                           last_slot;
    logic                           ram_hit;
    logic [3:0]                     ram_idx;

    function automatic logic low_ones(input logic [8:0] v, input logic [3:0] n);
        logic [8:0] m;
        m = 9'((10'h001 << n) - 10'h001);
        return (v & m) == m;
    endfunction : low_ones

    function automatic logic [1:0] slot_idx(input sld_pkg::sld_slot_e s);
        case (s)
            sld_pkg::SLOT_0: return 2'h0;
            sld_pkg::SLOT_1: return 2'h1;
            sld_pkg::SLOT_2: return 2'h2;
            sld_pkg::SLOT_3: return 2'h3;
            default:         return 2'h0;
        endcase
    endfunction : slot_idx

    // level of an electrode; commons and segments sit at opposite rails when selected
    function automatic logic [1:0] level(input logic sel, input logic is_com, input logic p);
        if (sel)
            return (is_com ^ p) ? `SLD_LVL_3 : `SLD_LVL_0;
        else if (is_com)
            return p ? `SLD_LVL_2 : `SLD_LVL_1;
        else
            return p ? `SLD_LVL_1 : `SLD_LVL_2;
    endfunction : level

    assign three_slot       = display_mode_reg[`SLD_BIT_SLOTS];
    assign booster_enable_o = display_mode_reg[`SLD_BIT_BOOST];
    assign gain_o           = boost_level_reg[`SLD_BIT_GAIN];
    assign ram_hit = (bus_i.addr >= `SLD_RAM_BASE) && (bus_i.addr <= `SLD_RAM_LAST);
    assign ram_idx = 4'(bus_i.addr - `SLD_RAM_BASE);

    // register and display memory access
    always_comb
    begin
        next_display_mode_reg = display_mode_reg;
        next_lcd_clock_reg    = lcd_clock_reg;
        next_boost_level_reg  = boost_level_reg;
        next_ram              = ram;
        next_rdata            = rdata_o;
        if (bus_i.wr)
        begin
            if (bus_i.addr == `SLD_ADDR_MODE)
                next_display_mode_reg = bus_i.wdata & `SLD_MODE_MASK;
            if (bus_i.addr == `SLD_ADDR_CLOCK)
                next_lcd_clock_reg = bus_i.wdata & `SLD_CLOCK_MASK;
            if (bus_i.addr == `SLD_ADDR_BOOST)
                next_boost_level_reg = bus_i.wdata & `SLD_BOOST_MASK;
            if (ram_hit)
                next_ram[ram_idx] = bus_i.wdata[3:0] & `SLD_RAM_MASK;
        end
        if (bus_i.rd)
        begin
            if (bus_i.addr == `SLD_ADDR_MODE)
                next_rdata = display_mode_reg;
            else if (bus_i.addr == `SLD_ADDR_CLOCK)
                next_rdata = lcd_clock_reg;
            else if (bus_i.addr == `SLD_ADDR_BOOST)
                next_rdata = boost_level_reg;
            else if (ram_hit)
                next_rdata = {4'h0, ram[ram_idx]};
            else
                next_rdata = `SLD_REG_RESET;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            display_mode_reg <= `SLD_REG_RESET;
            lcd_clock_reg    <= `SLD_REG_RESET;
            boost_level_reg  <= `SLD_REG_RESET;
            rdata_o          <= `SLD_REG_RESET;
        end
        else
        begin
            display_mode_reg <= next_display_mode_reg;
            lcd_clock_reg    <= next_lcd_clock_reg;
            boost_level_reg  <= next_boost_level_reg;
            rdata_o          <= next_rdata;
        end
    end

    // memory contents are not cleared by reset
    always_ff @(posedge clk_i)
    begin
        ram <= next_ram;
    end

    // source clock select, lcd clock divide, slot scan
    always_comb
    begin
        if (lcd_clock_reg[3:2] == 2'h0)
            src_tick = fxt_tick_i;
        else
            src_tick = low_ones({2'h0, prescale}, {2'h0, lcd_clock_reg[3:2]} + `SLD_SRC_SHIFT);
        lcd_tick = src_tick
                 && low_ones(lcd_div, {2'h0, lcd_clock_reg[1:0]} + `SLD_DIV_SHIFT);
        last_slot = (slot == sld_pkg::SLOT_3) || (three_slot && slot == sld_pkg::SLOT_2);
        next_prescale = prescale + 7'h01;
        next_lcd_div  = src_tick ? lcd_div + 9'h001 : lcd_div;
        next_slot     = slot;
        next_pol      = pol;
        if (lcd_tick)
        begin
            if (last_slot)
            begin
                next_slot = sld_pkg::SLOT_0;
                next_pol  = ~pol;
            end
            else
            begin
                case (slot)
                    sld_pkg::SLOT_0: next_slot = sld_pkg::SLOT_1;
                    sld_pkg::SLOT_1: next_slot = sld_pkg::SLOT_2;
                    sld_pkg::SLOT_2: next_slot = sld_pkg::SLOT_3;
                    default:         next_slot = sld_pkg::SLOT_0;
                endcase
            end
        end
        for (int c = 0; c < 4; c++)
        begin
            next_common_oe[c] = !(three_slot && c == 3);
            next_common[c] = level(slot_idx(slot) == 2'(c), 1'b1, pol);
            if (!display_mode_reg[`SLD_BIT_OUT_EN] || !next_common_oe[c])
                next_common[c] = `SLD_LVL_0;
        end
        for (int s = 0; s < `SLD_SEG_COUNT; s++)
        begin
            // bit 3 is only reached in slot 3, which three-slot scans skip
            next_segment[s] = level(display_mode_reg[`SLD_BIT_ON]
                                    && ram[s][slot_idx(slot)], 1'b0, pol);
            if (!display_mode_reg[`SLD_BIT_OUT_EN])
                next_segment[s] = `SLD_LVL_0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            prescale    <= 7'h00;
            lcd_div     <= 9'h000;
            slot        <= sld_pkg::SLOT_0;
            pol         <= 1'b0;
            segment_o   <= '0;
            common_o    <= '0;
            common_oe_o <= 4'h0;
        end
        else
        begin
            prescale    <= next_prescale;
            lcd_div     <= next_lcd_div;
            slot        <= next_slot;
            pol         <= next_pol;
            segment_o   <= next_segment;
            common_o    <= next_common;
            common_oe_o <= next_common_oe;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_boost_reset: assert property (@(posedge clk_i) disable iff (1'b0)
        sys_rst_i |=> boost_level_reg == `SLD_REG_RESET && !gain_o)
        else $error("boost level not cleared by reset");
    a_boost_read: assert property (bus_i.rd && bus_i.addr == `SLD_ADDR_BOOST
        |=> rdata_o[7:1] == 7'h00 && rdata_o[0] == $past(gain_o))
        else $error("boost register read wrong");
    a_ram_high_zero: assert property (bus_i.rd && ram_hit |=> rdata_o[7:4] == 4'h0)
        else $error("display memory upper bits not zero");
    a_ram_round_trip: assert property (bus_i.wr && ram_hit ##1
        (bus_i.rd && !bus_i.wr && bus_i.addr == $past(bus_i.addr))
        |=> rdata_o == {4'h0, $past(bus_i.wdata[3:0], 2)})
        else $error("display memory write not read back");
    a_gnd_off: assert property (!display_mode_reg[`SLD_BIT_OUT_EN]
        |=> segment_o == '0 && common_o == '0)
        else $error("outputs not grounded with buffers off");
    a_common_out_3_open: assert property (three_slot |=> !common_oe_o[3] && common_o[3] == `SLD_LVL_0)
        else $error("fourth common driven in three-slot mode");
    a_slot_walk: assert property (lcd_tick && slot == sld_pkg::SLOT_0 |=> slot == sld_pkg::SLOT_1)
        else $error("slot did not advance");
    a_pol_flip: assert property (lcd_tick && last_slot
        |=> slot == sld_pkg::SLOT_0 && pol != $past(pol))
        else $error("polarity did not flip after scan");
    a_seg_blank: assert property (display_mode_reg[`SLD_BIT_OUT_EN]
        && !display_mode_reg[`SLD_BIT_ON]
        |=> segment_o[0] == ($past(pol) ? `SLD_LVL_1 : `SLD_LVL_2))
        else $error("segment not at deselect with display off");

endmodule : sld_lcd_driver

`default_nettype wire

/* File: tb/sld_glass_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sld_glass_model (
    // clock and observation control
    input  wire logic                 clk_i,
    input  wire logic                 clr_i,
    input  wire logic                 three_slot_i,
    // panel electrodes
    input  wire logic [14:0][1:0]     segment_i,
    input  wire logic [3:0][1:0]      common_i,
    input  wire logic [3:0]           common_oe_i,
    // seen pixel polarities and scan faults
    output logic      [14:0][3:0]     pos_o,
    output logic      [14:0][3:0]     neg_o,
    output logic                      order_err_o
);
    int prev_sel;
    int cur_sel;
    int diff;

    // passive glass: it only watches the electrodes, it drives nothing back
    always @(posedge clk_i)
    begin
        cur_sel = -1;
        for (int c = 0; c < 4; c++)
            if (common_oe_i[c] && (common_i[c] == 2'h0 || common_i[c] == 2'h3))
                cur_sel = c;
        if (clr_i)
        begin
            pos_o <= '0;
            neg_o <= '0;
            order_err_o <= 1'b0;
            prev_sel = -1;
        end
        else
        begin
            // the scan must step to the next common only
            if (cur_sel >= 0 && prev_sel >= 0 && cur_sel != prev_sel
                && cur_sel != (prev_sel + 1) % (three_slot_i ? 3 : 4))
                order_err_o <= 1'b1;
            if (cur_sel >= 0)
                prev_sel = cur_sel;
            // full drive voltage across a pixel lights it, any polarity
            for (int s = 0; s < 15; s++)
                for (int c = 0; c < 4; c++)
                begin
                    diff = int'(common_i[c]) - int'(segment_i[s]);
                    if (common_oe_i[c] && diff == 3)
                        pos_o[s][c] <= 1'b1;
                    if (common_oe_i[c] && diff == -3)
                        neg_o[s][c] <= 1'b1;
                end
        end
    end
endmodule : sld_glass_model

`default_nettype wire

/* File: tb/sld_lcd_driver_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sld_map.svh"

module sld_lcd_driver_tb_top;
    // stands in for the long booster settling wait
    localparam int BOOST_WAIT = 16;
    logic clk, rst, fxt, clr, three;
    sld_pkg::sld_bus_s bus;
    logic [7:0] rdata;
    logic [14:0][1:0] seg;
    logic [3:0][1:0] com;
    logic [3:0] com_oe;
    logic boost_en, gain;
    logic [14:0][3:0] pos, neg, exp_px;
    logic order_err;
    int failures, compares, cycles;
    logic [7:0] m;

    sld_lcd_driver uut (.clk_i(clk), .sys_rst_i(rst), .bus_i(bus), .rdata_o(rdata),
        .fxt_tick_i(fxt), .segment_o(seg), .common_o(com), .common_oe_o(com_oe),
        .booster_enable_o(boost_en), .gain_o(gain));
    sld_glass_model glass (.clk_i(clk), .clr_i(clr), .three_slot_i(three), .segment_i(seg),
        .common_i(com), .common_oe_i(com_oe), .pos_o(pos), .neg_o(neg),
        .order_err_o(order_err));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(negedge clk)
        fxt <= rst ? 1'b0 : ~fxt;

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 16000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        bus.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        bus.rd = 1'b0;
        chk(64'(rdata), 64'(exp), "read data");
    endtask : rd

    // write immediately followed by a read of the same address
    task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(negedge clk);
        bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        bus = '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        bus.rd = 1'b0;
        chk(64'(rdata), 64'(exp), "write then read");
    endtask : wr_rd

    // length of one common slot in clock cycles for a given clock setting
    task automatic slot_time(input logic [7:0] cfg, input int exp_len);
        logic [3:0][1:0] last;
        int len;
        clr = 1'b1;
        wr(`SLD_ADDR_CLOCK, cfg);
        wr(`SLD_ADDR_MODE, 8'h40);
        repeat (BOOST_WAIT) @(negedge clk);
        wr(`SLD_ADDR_MODE, 8'h50);
        // skip the buffer switch-on and the first, possibly short, slot
        repeat (2)
        begin
            last = com;
            while (com === last)
                @(negedge clk);
        end
        last = com;
        len = 0;
        while (com === last)
        begin
            @(negedge clk);
            len++;
        end
        chk(64'(len), 64'(exp_len), "slot length");
        wr(`SLD_ADDR_MODE, 8'h40);
        wr(`SLD_ADDR_MODE, 8'h00);
        $display("test slot time clock=%h done", cfg);
    endtask : slot_time

    task automatic scan(input logic ts);
        three = ts;
        wr(`SLD_ADDR_CLOCK, 8'h00);
        wr(`SLD_ADDR_BOOST, 8'h00);
        m = {7'h00, ts};
        wr(`SLD_ADDR_MODE, m);
        m[6] = 1'b1;
        wr(`SLD_ADDR_MODE, m);
        repeat (BOOST_WAIT) @(negedge clk);
        chk(64'({seg, com, boost_en}), 64'h1, "buffers off grounded");
        m[4] = 1'b1;
        wr(`SLD_ADDR_MODE, m);
        clr = 1'b1;
        repeat (2) @(negedge clk);
        clr = 1'b0;
        repeat (1100) @(negedge clk);
        chk(64'(pos | neg), 64'h0, "display off lit pixel");
        chk(64'(com_oe), ts ? 64'h7 : 64'hF, "common enables");
        m[7] = 1'b1;
        wr(`SLD_ADDR_MODE, m);
        clr = 1'b1;
        repeat (2) @(negedge clk);
        clr = 1'b0;
        repeat (1100) @(negedge clk);
        for (int s = 0; s < 15; s++)
            for (int c = 0; c < 4; c++)
                exp_px[s][c] = (c < (ts ? 3 : 4)) && s[c];
        chk(64'(pos), 64'(exp_px), "pixels one polarity");
        chk(64'(neg), 64'(exp_px), "pixels other polarity");
        chk(64'(order_err), 64'h0, "scan order");
        m[7] = 1'b0;
        wr(`SLD_ADDR_MODE, m);
        m[4] = 1'b0;
        wr(`SLD_ADDR_MODE, m);
        m[6] = 1'b0;
        wr(`SLD_ADDR_MODE, m);
        $display("test scan three_slot=%0d done", ts);
    endtask : scan

    initial
    begin
        rst = 1'b1;
        clr = 1'b1;
        three = 1'b0;
        bus = '0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(`SLD_ADDR_MODE, 8'h00);
        rd(`SLD_ADDR_CLOCK, 8'h00);
        rd(`SLD_ADDR_BOOST, 8'h00);
        rd(16'hFFB1, 8'h00);
        wr(`SLD_ADDR_BOOST, 8'hFF);
        rd(`SLD_ADDR_BOOST, 8'h01);
        chk(64'(gain), 64'h1, "gain level");
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(`SLD_ADDR_BOOST, 8'h00);
        chk(64'(gain), 64'h0, "gain after reset");
        $display("test registers done");
        wr_rd(`SLD_RAM_BASE, 8'h5A, 8'h0A);
        for (int n = 0; n < 15; n++)
            wr(`SLD_RAM_BASE + 16'(n), 8'hF0 | 8'(n));
        for (int n = 0; n < 15; n++)
            rd(`SLD_RAM_BASE + 16'(n), 8'(n));
        rd(16'hFA0F, 8'h00);
        $display("test display memory done");
        scan(1'b0);
        scan(1'b1);
        // subsystem tick every second cycle, lcd clock /2^7: 2 * 128 cycles per slot
        slot_time(8'h01, 256);
        // source fx/2^5, lcd clock /2^6: 32 * 64 cycles per slot
        slot_time(8'h04, 2048);
        close_out();
    end
endmodule : sld_lcd_driver_tb_top

`default_nettype wire
